// *** dsdc_dac_model.sv ***
// behavioural dual 14-bit converter register model facing the host
module dsdc_dac_model (
  // serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic sdi_i,
  // load and preset pins
  input wire logic output_load_strobe_n_i,
  input wire logic preset_n_i,
  input wire logic preset_sel_i,
  // register contents and host misuse flag
  output logic [13:0] in_a_o,
  output logic [13:0] in_b_o,
  output logic [13:0] out_a_o,
  output logic [13:0] out_b_o,
  output logic misuse_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] shift_reg;
  int edges;
  // two channels, input and output register each
  task automatic preset_all();
    in_a_o = preset_sel_i ? 14'h2000 : 14'h0000;
    in_b_o = in_a_o;
    out_a_o = in_a_o;
    out_b_o = in_a_o;
  endtask
  // power-up preset waits until the select pin is driven
  initial begin
    misuse_o = 1'b0;
    edges = 0;
    shift_reg = 16'h0000;
    wait (preset_sel_i !== 1'bx);
    preset_all();
  end
  always @(negedge preset_n_i or preset_sel_i) begin
    if (preset_n_i === 1'b0) preset_all();
  end
  always @(negedge cs_n_i) edges = 0;
  // deselected: clock edges leave the shift register alone
  always @(posedge sclk_i) begin
    if (cs_n_i === 1'b0) begin
      shift_reg = {shift_reg[14:0], sdi_i};
      edges = edges + 1;
    end
  end
  always @(posedge cs_n_i) begin
    if (edges > 0 && sclk_i !== 1'b0) misuse_o = 1'b1;
    // only the last 16 bits count; short frames load nothing
    if (edges >= 16 && preset_n_i === 1'b1) begin
      if (shift_reg[14]) in_a_o = shift_reg[13:0];
      if (shift_reg[15]) in_b_o = shift_reg[13:0];
    end
  end
  // strobe high holds the outputs, rising edge included
  always @* begin
    if (output_load_strobe_n_i === 1'b0 && preset_n_i !== 1'b0) begin
      out_a_o = in_a_o;
      out_b_o = in_b_o;
    end
  end
endmodule

// *** dsdc_host.sv ***
// wishbone-controlled host that loads a dual 14-bit dac over three wires
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`include "dsdc_map.svh"
module dsdc_host #(
  parameter int DIV_W = 16,
  parameter int GAP_TICKS = `DSDC_GAP_TICKS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial pins to the dac
  output logic cs_n_o,
  output logic sclk_o,
  output logic sdi_o,
  // load and preset pins to the dac
  output logic output_load_strobe_n_o,
  output logic preset_n_o,
  output logic preset_sel_o,
  // status
  output dsdc_pkg::dsdc_state_t state_o
);
  import dsdc_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
    merge16 = old_v;
    if (sel[0]) begin
      merge16[7:0] = new_v[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = new_v[15:8];
    end
  endfunction

  dsdc_if link();
  dsdc_state_t state;
  dsdc_state_t state_next;
  logic [`DSDC_CTRL_W-1:0] ctrl_reg;
  dsdc_word_t data_reg;
  logic [DIV_W-1:0] div_reg;
  logic done_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic cs_n_reg;
  logic strobe_n_reg;
  logic preset_n_reg;
  logic start_reg;
  logic tick;

  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire wr = req && wb_we_i;
  wire hit_ctrl = (wb_adr_i == `DSDC_OFF_CTRL);
  wire hit_data = (wb_adr_i == `DSDC_OFF_DATA);
  wire hit_stat = (wb_adr_i == `DSDC_OFF_STAT);
  wire hit_div = (wb_adr_i == `DSDC_OFF_DIV);
  wire wr_ctrl = wr && hit_ctrl && wb_sel_i[0];
  wire wr_stat = wr && hit_stat && wb_sel_i[0];
  wire idle = (state == M_IDLE);

  // write-one commands, only honoured while idle
  wire go_cmd = wr_ctrl && wb_dat_i[`DSDC_CTRL_GO] && idle;
  wire preset_cmd = wr_ctrl && wb_dat_i[`DSDC_CTRL_PRESET] && idle;
  wire load_cmd = wr_ctrl && wb_dat_i[`DSDC_CTRL_LOAD] && idle;
  wire data_lock = !idle;

  wire [`DSDC_CTRL_W-1:0] ctrl_rd = {2'h0, ctrl_reg[`DSDC_CTRL_PSEL:1], 1'b0};
  wire [31:0] stat_rd = {30'h0, done_reg, !idle};
  wire [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl_rd}
                     : hit_data ? {16'h0, data_reg}
                     : hit_stat ? stat_rd
                     : hit_div ? {{(32 - DIV_W){1'b0}}, div_reg}
                     : 32'h0000_0000;

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      rdat_reg <= req && !wb_we_i ? rd_mux : 32'h0000_0000;
    end
  end

  // register writes; data is frozen while a frame runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `DSDC_CTRL_RST;
      data_reg <= `DSDC_DATA_RST;
      div_reg <= DIV_W'(`DSDC_DIV_RST);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wb_dat_i[`DSDC_CTRL_W-1:0];
      end
      if (wr && hit_data && !data_lock) begin
        data_reg <= merge16(data_reg, wb_dat_i, wb_sel_i);
      end
      if (wr && hit_div) begin
        div_reg <= DIV_W'(merge16(16'(div_reg), wb_dat_i, wb_sel_i));
      end
    end
  end

  // frame-done flag: hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else if (link.done) begin
      done_reg <= 1'b1;
    end else if (wr_stat && wb_dat_i[`DSDC_STAT_DONE]) begin
      done_reg <= 1'b0;
    end
  end

  dsdc_tick #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_i(div_reg),
    .tick_o(tick)
  );

  assign link.tick = tick;
  assign link.start = start_reg;
  assign link.split = ctrl_reg[`DSDC_CTRL_SPLIT];
  assign link.word = data_reg;

  dsdc_shift #(
    .GAP_TICKS(GAP_TICKS)
  ) u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .link(link)
  );

  // sequencer; each pin step but the shift waits one divider tick
  always_comb begin
    state_next = state;
    case (state)
      M_IDLE: begin
        if (go_cmd) begin
          state_next = M_SETUP;
        end else if (preset_cmd) begin
          state_next = M_PRESET;
        end else if (load_cmd) begin
          state_next = M_LOAD;
        end
      end
      M_SETUP: if (tick) begin
        state_next = M_SHIFT;
      end
      M_SHIFT: if (link.done) begin
        state_next = M_HOLD;
      end
      M_HOLD: if (tick) begin
        state_next = M_CSHI;
      end
      M_CSHI: if (tick) begin
        state_next = ctrl_reg[`DSDC_CTRL_AUTO] ? M_LOAD : M_IDLE;
      end
      M_LOAD: if (tick) begin
        state_next = M_IDLE;
      end
      M_PRESET: if (tick) begin
        state_next = M_IDLE;
      end
      default: state_next = M_IDLE;
    endcase
  end

  // shifter start, once, on leaving setup
  wire start_next = (state == M_SETUP) && tick;
  // select falls on go, rises on the tick after the last low clock
  wire cs_next = !(state_next == M_SETUP || state_next == M_SHIFT
                   || state_next == M_HOLD);
  // strobe held low in transparent mode or pulsed for one tick
  wire strobe_next = !(ctrl_reg[`DSDC_CTRL_TRANSP]
                       || state_next == M_LOAD);
  wire preset_next = !(state_next == M_PRESET);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= M_IDLE;
      start_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      strobe_n_reg <= 1'b1;
      preset_n_reg <= 1'b1;
    end else begin
      state <= state_next;
      start_reg <= start_next;
      cs_n_reg <= cs_next;
      strobe_n_reg <= strobe_next;
      preset_n_reg <= preset_next;
    end
  end

  assign cs_n_o = cs_n_reg;
  assign sclk_o = link.sclk;
  assign sdi_o = link.sdi;
  assign output_load_strobe_n_o = strobe_n_reg;
  assign preset_n_o = preset_n_reg;
  assign preset_sel_o = ctrl_reg[`DSDC_CTRL_PSEL];
  assign state_o = state;

  // helper: rising serial clock edges in the current frame
  logic sclk_q;
  logic [5:0] edge_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      edge_cnt <= 6'h00;
    end else begin
      sclk_q <= link.sclk;
      if (state == M_SETUP) begin
        edge_cnt <= 6'h00;
      end else if (link.sclk && !sclk_q) begin
        edge_cnt <= edge_cnt + 6'h01;
      end
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence frame_open_s;
    $fell(cs_n_o) ##0 !sclk_o;
  endsequence

  sequence frame_close_s;
    (state == M_HOLD && !cs_n_o && !sclk_o) ##1 !cs_n_o;
  endsequence

  cs_clock_low_a: assert property ($rose(cs_n_o) |-> !sclk_o)
    else $error("select raised with serial clock high");
  frame_edges_a: assert property ($rose(cs_n_o) |-> edge_cnt == 6'h10)
    else $error("frame closed without sixteen clock edges");
  frame_open_a: assert property ($fell(cs_n_o) |-> frame_open_s)
    else $error("select fell with serial clock high");
  frame_close_a: assert property (link.done |-> ##1 frame_close_s)
    else $error("select not held low after last bit");
  cs_low_shift_a: assert property (link.busy |-> !cs_n_o)
    else $error("select high while bits still moving");
  word_layout_a: assert property (
    start_reg |-> link.word[`DSDC_SEL_HI:`DSDC_SEL_LO] == data_reg[15:14]
      && link.word[`DSDC_CODE_W-1:0] == $past(data_reg[13:0]))
    else $error("word layout does not match data register");
  clock_idle_a: assert property (cs_n_o && $past(cs_n_o) |-> !sclk_o)
    else $error("serial clock active outside a frame");
  strobe_quiet_a: assert property (
    !cs_n_o |-> output_load_strobe_n_o || ctrl_reg[`DSDC_CTRL_TRANSP])
    else $error("load strobe pulsed during a frame");
endmodule

// *** dsdc_host_tb.sv ***
// self-checking bench for the dac load host and its converter model
`include "dsdc_map.svh"
module dsdc_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat;
  logic wb_ack, cs_n, sclk, sdi, ld_n, pr_n, psel, misuse;
  logic [13:0] in_a, in_b, out_a, out_b;
  int miscompares = 0;
  int checks_done = 0;
  logic [13:0] codes [4] = '{14'h2A5C, 14'h3FFF, 14'h1234, 14'h0001};

  always #20 clk_i = ~clk_i;

  dsdc_host dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .cs_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi), .output_load_strobe_n_o(ld_n), .preset_n_o(pr_n),
    .preset_sel_o(psel), .state_o()
  );
  dsdc_dac_model dac (
    .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
    .output_load_strobe_n_i(ld_n), .preset_n_i(pr_n),
    .preset_sel_i(psel), .in_a_o(in_a), .in_b_o(in_b), .out_a_o(out_a),
    .out_b_o(out_b), .misuse_o(misuse)
  );

  task automatic tally_and_finish();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_code(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; ack is seen as sampled at the edge
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    if (n >= 64) miscompares++;
    rd = wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    wb_cycle(1'b1, a, d, unused);
  endtask

  task automatic wb_read(input logic [7:0] a, output logic [31:0] d);
    wb_cycle(1'b0, a, 32'h0, d);
  endtask

  task automatic wait_idle();
    logic [31:0] st;
    int n;
    n = 0;
    do begin
      wb_read(`DSDC_OFF_STAT, st);
      n++;
    end while (st[0] !== 1'b0 && n < 200);
    if (n >= 200) miscompares++;
  endtask

  task automatic frame(input logic [15:0] w, input logic [31:0] ctrl);
    wb_write(`DSDC_OFF_DATA, {16'h0000, w});
    wb_write(`DSDC_OFF_CTRL, ctrl);
    wait_idle();
  endtask

  initial begin
    logic [31:0] rd;
    logic [13:0] ea;
    logic [13:0] eb;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check_code(in_a, 14'h0000);
    check_code(out_b, 14'h0000);
    wb_write(8'h40, 32'hFFFFFFFF);
    wb_read(8'h40, rd);
    check_bus(rd, 32'h00000000);
    ea = 14'h0000;
    eb = 14'h0000;
    // every select code; odd ones go out as two bytes
    for (int s = 0; s < 4; s++) begin
      frame({s[1:0], codes[s]}, s[0] ? 32'h03 : 32'h01);
      if (s[0]) ea = codes[s];
      if (s[1]) eb = codes[s];
      check_code(in_a, ea);
      check_code(in_b, eb);
      check_code(out_a, 14'h0000);
    end
    wb_write(`DSDC_OFF_CTRL, 32'h40);
    wait_idle();
    check_code(out_a, ea);
    check_code(out_b, eb);
    frame({2'b11, 14'h0F0F}, 32'h05);
    check_code(out_a, 14'h0F0F);
    check_code(out_b, 14'h0F0F);
    wb_write(`DSDC_OFF_CTRL, 32'h30);
    wait_idle();
    check_code(in_b, 14'h2000);
    check_code(out_a, 14'h2000);
    wb_write(`DSDC_OFF_CTRL, 32'h20);
    wait_idle();
    check_code(in_a, 14'h0000);
    check_code(out_b, 14'h0000);
    // strobe held low: outputs follow the input registers
    wb_write(`DSDC_OFF_CTRL, 32'h08);
    frame({2'b10, 14'h1C3A}, 32'h09);
    check_code(out_b, 14'h1C3A);
    check_code(out_a, 14'h0000);
    check_bus({31'h0, misuse}, 32'h00000000);
    wb_read(`DSDC_OFF_CTRL, rd);
    check_bus(rd, 32'h00000008);
    wb_read(`DSDC_OFF_STAT, rd);
    check_bus(rd, 32'h00000002);
    wb_write(`DSDC_OFF_STAT, 32'h02);
    wb_read(`DSDC_OFF_STAT, rd);
    check_bus(rd, 32'h00000000);
    wb_read(`DSDC_OFF_DIV, rd);
    check_bus(rd, 32'h00000003);
    tally_and_finish();
  end

  // the whole run needs about a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule

// *** dsdc_if.sv ***
// link between the sequencer and the serial shifter
interface dsdc_if;
  import dsdc_pkg::*;
  logic tick;
  logic start;
  logic split;
  dsdc_word_t word;
  logic busy;
  logic done;
  logic sclk;
  logic sdi;
  modport ctl(output tick, start, split, word, input busy, done, sclk, sdi);
  modport shf(input tick, start, split, word, output busy, done, sclk, sdi);
endinterface

// *** dsdc_map.svh ***
// register map, field positions and timing counts of the dac load host
// Function
// - each transfer is a 16-bit word, most significant bit first.
// - bit 15 upper channel select, bit 14 lower, bits 13..0 code.
// - host holds serial clock low while raising select.
// - byte-wide host may send two right-justified bytes, select kept low.
`ifndef DSDC_MAP_SVH
`define DSDC_MAP_SVH
`define DSDC_OFF_CTRL 8'h00
`define DSDC_OFF_DATA 8'h04
`define DSDC_OFF_STAT 8'h08
`define DSDC_OFF_DIV 8'h0C
`define DSDC_CTRL_GO 0
`define DSDC_CTRL_SPLIT 1
`define DSDC_CTRL_AUTO 2
`define DSDC_CTRL_TRANSP 3
`define DSDC_CTRL_PSEL 4
`define DSDC_CTRL_PRESET 5
`define DSDC_CTRL_LOAD 6
`define DSDC_CTRL_W 7
`define DSDC_STAT_BUSY 0
`define DSDC_STAT_DONE 1
`define DSDC_SEL_HI 15
`define DSDC_SEL_LO 14
`define DSDC_CODE_W 14
`define DSDC_WORD_W 16
`define DSDC_CTRL_RST 7'h00
`define DSDC_DATA_RST 16'h0000
`define DSDC_DIV_RST 16'h0003
`define DSDC_GAP_TICKS 4
`endif

// *** dsdc_pkg.sv ***
// types shared by the dac load host modules
package dsdc_pkg;
  typedef logic [15:0] dsdc_word_t;
  typedef enum logic [6:0] {
    M_IDLE = 7'h01,
    M_SETUP = 7'h02,
    M_SHIFT = 7'h04,
    M_HOLD = 7'h08,
    M_CSHI = 7'h10,
    M_LOAD = 7'h20,
    M_PRESET = 7'h40
  } dsdc_state_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_LOW = 4'h2,
    S_HIGH = 4'h4,
    S_GAP = 4'h8
  } dsdc_shf_t;
endpackage

// *** dsdc_shift.sv ***
// serial shifter: 16 bits out msb first, optional gap between bytes
`include "dsdc_map.svh"
module dsdc_shift #(
  parameter int GAP_TICKS = `DSDC_GAP_TICKS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sequencer side
  dsdc_if.shf link
);
  import dsdc_pkg::*;
  dsdc_shf_t state;
  dsdc_word_t sh_reg;
  logic [4:0] cnt_reg;
  logic [3:0] gap_reg;
  logic sclk_reg;
  logic sdi_reg;
  logic done_reg;
  wire last_bit = (cnt_reg == 5'h0F);
  wire byte_gap = link.split && (cnt_reg == 5'h07);
  wire gap_end = (gap_reg == 4'(GAP_TICKS - 1));

  assign link.busy = (state != S_IDLE);
  assign link.done = done_reg;
  assign link.sclk = sclk_reg;
  assign link.sdi = sdi_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      sh_reg <= '0;
      cnt_reg <= '0;
      gap_reg <= '0;
      sclk_reg <= 1'b0;
      sdi_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      case (state)
        S_IDLE: if (link.start) begin
          sh_reg <= link.word;
          sdi_reg <= link.word[15];
          cnt_reg <= '0;
          state <= S_LOW;
        end
        S_LOW: if (link.tick) begin
          sclk_reg <= 1'b1;
          state <= S_HIGH;
        end
        S_HIGH: if (link.tick) begin
          sclk_reg <= 1'b0;
          cnt_reg <= cnt_reg + 5'h01;
          sh_reg <= {sh_reg[14:0], 1'b0};
          sdi_reg <= sh_reg[14];
          gap_reg <= '0;
          if (last_bit) begin
            done_reg <= 1'b1;
            state <= S_IDLE;
          end else if (byte_gap) begin
            state <= S_GAP;
          end else begin
            state <= S_LOW;
          end
        end
        S_GAP: if (link.tick) begin
          gap_reg <= gap_reg + 4'h1;
          if (gap_end) begin
            state <= S_LOW;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  sdi_stable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    link.sclk && $past(link.sclk) |-> $stable(link.sdi))
    else $error("data moved while serial clock high");
  msb_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_HIGH |-> link.sdi == sh_reg[15])
    else $error("data pin is not the current top bit");
  byte_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state == S_GAP |-> !link.sclk && cnt_reg == 5'h08)
    else $error("byte gap outside bit eight or clock high");
  word_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    link.done |-> cnt_reg == 5'h10 && !link.sclk)
    else $error("frame ended without sixteen bits");
endmodule

// *** dsdc_tick.sv ***
// divider giving a one-cycle enable every div_i+1 clocks
module dsdc_tick #(
  parameter int DIV_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // divide setting and enable out
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  logic [DIV_W-1:0] cnt_reg;
  wire wrap = (cnt_reg >= div_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      tick_o <= wrap;
    end
  end
endmodule
